// ==== core/isorw_pkg.sv ====
// Purpose: Shared constants for the isolator refresh/watchdog block
// Assumes: 10 MHz system clock, four channels
// Notes:   Times are kept in their own unit; cycle counts derive from them
package isorw_pkg;
    localparam int unsigned NCH           = 4;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned NS_PER_US     = 1000;
    // Pulse across the barrier, least time, rounded up, at least one cycle
    localparam int unsigned PULSE_NS      = 1;
    localparam int unsigned PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Quiet time before refresh, least time, rounded up
    localparam int unsigned REFRESH_US    = 140;
    localparam int unsigned REFRESH_CYC   =
        (REFRESH_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Silence before watchdog fires, rounded down
    localparam int unsigned WATCHDOG_US   = 200;
    localparam int unsigned WATCHDOG_CYC  = (WATCHDOG_US * NS_PER_US) / CLK_PERIOD_NS;
    // Glitch filter threshold in cycles (stable cycles needed)
    localparam int unsigned GLITCH_CYC    = 3;
    // Barrier FIFO shape
    localparam int unsigned FIFO_DEPTH    = 4;
    localparam int unsigned WORD_W        = 2 * NCH;
    // Counter width
    localparam int unsigned CNT_W         = 12;
    typedef logic [CNT_W-1:0] isorw_cnt_t;
    localparam isorw_cnt_t  CNT_ZERO      = 12'h000;
    localparam isorw_cnt_t  CNT_ONE       = 12'h001;
    localparam logic        LVL_LOW       = 1'h0;
    // Channel direction: bit set means input on side 1, output on side 2
    localparam logic [NCH-1:0] DIR_DEFAULT = 4'h3;
    localparam logic [NCH-1:0] WD_DEFAULT  = 4'hF;
endpackage : isorw_pkg

// ==== core/isorw_fifo_if.sv ====
// Purpose: Valid/ready carrier between the barrier encoder, FIFO and decoder
// Assumes: Single clock domain
// Notes:   Source drives push side, sink drives pop_ready
`timescale 1ns/1ns
`default_nettype none
interface isorw_fifo_if #(parameter int unsigned W = 8);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;
    modport fifo (input push_valid, input push_data, output push_ready,
                  output pop_valid, output pop_data, input pop_ready);
    modport src  (output push_valid, output push_data, input push_ready);
    modport snk  (input pop_valid, input pop_data, output pop_ready);
endinterface : isorw_fifo_if
`default_nettype wire

// ==== core/isorw_fifo.sv ====
// Purpose: Small flip-flop FIFO holding barrier pulse words
// Assumes: DEPTH is a power of two
// Notes:   Full and empty from pointers with one extra wrap bit
`timescale 1ns/1ns
`default_nettype none
module isorw_fifo
    import isorw_pkg::*;
#(
    parameter int unsigned WIDTH = WORD_W,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic  sys_clk_in,
    input  wire logic  rst_b_in,
    input  wire logic  clk_en_in,
    // Queue ports
    isorw_fifo_if.fifo q
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      rd_ptr_ff;
    logic [AW:0]      used;
    logic             do_push;
    logic             do_pop;

    // Occupancy and handshakes
    assign used         = wr_ptr_ff - rd_ptr_ff;
    assign q.push_ready = (used != (AW+1)'(DEPTH));
    assign q.pop_valid  = (used != '0);
    assign q.pop_data   = mem_ff[rd_ptr_ff[AW-1:0]];
    assign do_push      = clk_en_in & q.push_valid & q.push_ready;
    assign do_pop       = clk_en_in & q.pop_valid & q.pop_ready;

    // Pointers
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (do_push) wr_ptr_ff <= wr_ptr_ff + (AW+1)'(1);
            if (do_pop)  rd_ptr_ff <= rd_ptr_ff + (AW+1)'(1);
        end
    end

    // Storage, no reset needed: read only when valid
    always_ff @(posedge sys_clk_in) begin
        if (do_push) mem_ff[wr_ptr_ff[AW-1:0]] <= q.push_data;
    end
endmodule : isorw_fifo
`default_nettype wire

// ==== core/isorw_top.sv ====
// Purpose: Four-channel isolator model with glitch filter, refresh and watchdog
// Assumes: Pins are asynchronous to sys_clk_in; power-good pins model supplies
// Notes:   Barrier pulses travel as words through a small FIFO to the decoders
//
// Summary of operation
// - Every accepted input edge sends a one-cycle coded pulse carrying its direction.
// - Each output is a latch set by a rising pulse and reset by a falling pulse.
// - With refresh on, a channel quiet for 140 us resends its current level.
// - With watchdog on, an output that gets no pulse for 200 us goes to its default.
// - The watchdog default level of each channel is a build-time parameter.
// - Both enables low turn refresh and watchdog on.
// - Both enables high turn them off, so outputs change only on edges or when output-side power is lost.
// - An input change shorter than the filter threshold never reaches the output.
// - With refresh on, a near-threshold pulse may stretch until refresh or the next edge.
// - In low-power mode a level set before the output side powers up is not sent.
// - Once both sides are up, the first input edge makes the output agree.
`timescale 1ns/1ns
`default_nettype none
module isorw_top
    import isorw_pkg::*;
#(
    parameter logic [NCH-1:0] CHAN_DIR    = DIR_DEFAULT,
    parameter logic [NCH-1:0] WD_LEVEL    = WD_DEFAULT,
    parameter int unsigned    GLITCH      = GLITCH_CYC,
    parameter int unsigned    DEC_GAP     = PULSE_CYC
) (
    // Clock, reset, enable
    input  wire logic sys_clk_in,
    input  wire logic rst_b_in,
    input  wire logic clk_en_in,
    // Side enables and supply status
    input  wire logic side1_refresh_enable_n_in,
    input  wire logic side2_refresh_enable_n_in,
    input  wire logic side1_power_ok_in,
    input  wire logic side2_power_ok_in,
    // Channel inputs
    input  wire logic chan_a_in,
    input  wire logic chan_b_in,
    input  wire logic chan_c_in,
    input  wire logic chan_d_in,
    // Channel outputs
    output logic      chan_a_out,
    output logic      chan_b_out,
    output logic      chan_c_out,
    output logic      chan_d_out
);
    localparam int unsigned SW = NCH + 4;
    localparam isorw_cnt_t  GL_LAST = CNT_W'(GLITCH - 1);
    localparam isorw_cnt_t  RF_LAST = CNT_W'(REFRESH_CYC - 1);
    localparam isorw_cnt_t  WD_LAST = CNT_W'(WATCHDOG_CYC - 1);
    localparam isorw_cnt_t  GAP_CNT = CNT_W'(DEC_GAP);

    logic [SW-1:0]  meta_ff;
    logic [SW-1:0]  sync_ff;
    logic [NCH-1:0] lvl;
    logic           en1_n;
    logic           en2_n;
    logic           pwr1;
    logic           pwr2;
    logic [NCH-1:0] pend_ff;
    logic [NCH-1:0] pend_lvl_ff;
    logic [NCH-1:0] out_ff;
    logic [NCH-1:0] set_evt;
    logic [NCH-1:0] set_lvl;
    isorw_cnt_t     busy_ff;
    logic           push_ok;
    logic           take;

    isorw_fifo_if #(.W(WORD_W)) barrier ();

    // Two-stage synchroniser for all pins; only sync_ff is read
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (clk_en_in) begin
            meta_ff <= {side2_power_ok_in, side1_power_ok_in,
                        side2_refresh_enable_n_in, side1_refresh_enable_n_in,
                        chan_d_in, chan_c_in, chan_b_in, chan_a_in};
            sync_ff <= meta_ff;
        end
    end

    assign lvl   = sync_ff[NCH-1:0];
    assign en1_n = sync_ff[NCH];
    assign en2_n = sync_ff[NCH+1];
    assign pwr1  = sync_ff[NCH+2];
    assign pwr2  = sync_ff[NCH+3];

    // Encoder side: word is {pulse valid per channel, level per channel}
    assign push_ok             = clk_en_in & barrier.push_valid & barrier.push_ready;
    assign barrier.push_valid  = |pend_ff;
    assign barrier.push_data   = {pend_ff, pend_lvl_ff};

    // Decoder side: one word per gap, so bursts back up into the FIFO
    assign barrier.pop_ready   = (busy_ff == CNT_ZERO);
    assign take                = clk_en_in & barrier.pop_valid & barrier.pop_ready;

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_ff <= CNT_ZERO;
        end else if (clk_en_in) begin
            if (take)                   busy_ff <= GAP_CNT;
            else if (busy_ff != CNT_ZERO) busy_ff <= busy_ff - CNT_ONE;
        end
    end

    isorw_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_barrier (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .clk_en_in  (clk_en_in),
        .q          (barrier)
    );

    // One identical channel per generate pass
    for (genvar i = 0; i < NCH; i++) begin : g_chan
        logic       in_pwr;
        logic       out_pwr;
        logic       rfr_on;
        logic       wd_on;
        logic       flt_ff;
        isorw_cnt_t glt_ff;
        isorw_cnt_t quiet_ff;
        isorw_cnt_t wd_ff;
        logic       edge_evt;
        logic       rfr_evt;
        logic       rx;

        // Each side's enable rules its own end of the channel
        assign in_pwr   = CHAN_DIR[i] ? pwr1 : pwr2;
        assign out_pwr  = CHAN_DIR[i] ? pwr2 : pwr1;
        assign rfr_on   = ~(CHAN_DIR[i] ? en1_n : en2_n);
        assign wd_on    = ~(CHAN_DIR[i] ? en2_n : en1_n);
        assign edge_evt = in_pwr & (lvl[i] != flt_ff) & (glt_ff == GL_LAST);
        assign rfr_evt  = in_pwr & rfr_on & ~edge_evt & (quiet_ff == RF_LAST);
        assign set_evt[i] = edge_evt | rfr_evt;
        assign set_lvl[i] = edge_evt ? lvl[i] : flt_ff;
        assign rx       = take & barrier.pop_data[NCH+i] & out_pwr;

        // Glitch filter: change must hold GLITCH cycles; unpowered input just tracks
        always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                flt_ff <= LVL_LOW;
                glt_ff <= CNT_ZERO;
            end else if (clk_en_in) begin
                if (!in_pwr) begin
                    flt_ff <= lvl[i];
                    glt_ff <= CNT_ZERO;
                end else if (lvl[i] == flt_ff) begin
                    glt_ff <= CNT_ZERO;
                end else if (edge_evt) begin
                    flt_ff <= lvl[i];
                    glt_ff <= CNT_ZERO;
                end else begin
                    glt_ff <= glt_ff + CNT_ONE;
                end
            end
        end

        // Quiet timer; a filtered-level mismatch is healed by the next refresh
        always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                quiet_ff <= CNT_ZERO;
            end else if (clk_en_in) begin
                if (set_evt[i] || !rfr_on || !in_pwr) quiet_ff <= CNT_ZERO;
                else                                  quiet_ff <= quiet_ff + CNT_ONE;
            end
        end

        // Pending pulse: a new event wins over the clear of the one pushed
        always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                pend_ff[i]     <= 1'h0;
                pend_lvl_ff[i] <= LVL_LOW;
            end else if (clk_en_in) begin
                if (set_evt[i]) begin
                    pend_ff[i]     <= 1'h1;
                    pend_lvl_ff[i] <= set_lvl[i];
                end else if (push_ok) begin
                    pend_ff[i]     <= 1'h0;
                end
            end
        end

        // Bistable decoder with watchdog; unpowered output sits at default
        always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                out_ff[i] <= WD_LEVEL[i];
                wd_ff     <= CNT_ZERO;
            end else if (clk_en_in) begin
                if (!out_pwr) begin
                    out_ff[i] <= WD_LEVEL[i];
                    wd_ff     <= CNT_ZERO;
                end else if (rx) begin
                    out_ff[i] <= barrier.pop_data[i];
                    wd_ff     <= CNT_ZERO;
                end else if (!wd_on) begin
                    wd_ff     <= CNT_ZERO;
                end else if (wd_ff == WD_LAST) begin
                    out_ff[i] <= WD_LEVEL[i];
                end else begin
                    wd_ff     <= wd_ff + CNT_ONE;
                end
            end
        end
    end

    // Outputs straight from the decoder latches
    assign chan_a_out = out_ff[0];
    assign chan_b_out = out_ff[1];
    assign chan_c_out = out_ff[2];
    assign chan_d_out = out_ff[3];
endmodule : isorw_top
`default_nettype wire

// ==== dv/isorw_assertions.sv ====
// Purpose: Concurrent checks on the isolator top ports
// Assumes: Both enables move together; side 1 loss is the watchdog case
// Notes:   Helper counters turn long waits into fixed bounds
`timescale 1ns/1ns
`default_nettype none
module isorw_chk
    import isorw_pkg::*;
#(
    parameter logic [NCH-1:0] CHAN_DIR = DIR_DEFAULT,
    parameter logic [NCH-1:0] WD_LEVEL = WD_DEFAULT
) (
    // Clock, reset, enable
    input  wire logic sys_clk_in,
    input  wire logic rst_b_in,
    input  wire logic clk_en_in,
    // Side enables and supplies
    input  wire logic side1_refresh_enable_n_in,
    input  wire logic side2_refresh_enable_n_in,
    input  wire logic side1_power_ok_in,
    input  wire logic side2_power_ok_in,
    // Channel pins
    input  wire logic chan_a_in,
    input  wire logic chan_b_in,
    input  wire logic chan_c_in,
    input  wire logic chan_d_in,
    input  wire logic chan_a_out,
    input  wire logic chan_b_out,
    input  wire logic chan_c_out,
    input  wire logic chan_d_out
);
    logic [3:0]       ins, outs, ins_q_ff;
    logic [3:0][4:0]  stab_ff;
    logic [3:0][10:0] rfr_ff;
    logic [11:0]      dn_ff;
    logic             up, lo, lo_q_ff;
    assign ins  = {chan_d_in, chan_c_in, chan_b_in, chan_a_in};
    assign outs = {chan_d_out, chan_c_out, chan_b_out, chan_a_out};
    assign up   = side1_power_ok_in & side2_power_ok_in;
    assign lo   = !side1_refresh_enable_n_in & !side2_refresh_enable_n_in;
    // Quiet time per channel; a power loss voids the edge count until the next edge, the refresh count restarts at power-up
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ins_q_ff <= 4'h0;
            stab_ff  <= '0;
            rfr_ff   <= '0;
        end else begin
            ins_q_ff <= ins;
            for (int i = 0; i < 4; i++) begin
                if (ins[i] != ins_q_ff[i]) begin
                    stab_ff[i] <= 5'h01;
                end else if (!up) begin
                    stab_ff[i] <= 5'h00;
                end else if (clk_en_in && stab_ff[i] != 5'h00 && stab_ff[i] != 5'h1F) begin
                    stab_ff[i] <= stab_ff[i] + 5'h01;
                end
                if (ins[i] != ins_q_ff[i] || !up || !lo) begin
                    rfr_ff[i] <= 11'h000;
                end else if (clk_en_in && rfr_ff[i] != 11'h7FF) begin
                    rfr_ff[i] <= rfr_ff[i] + 11'h001;
                end
            end
        end
    end
    // Side 1 down, side 2 up; restarts on a mode change
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lo_q_ff <= 1'h0;
            dn_ff   <= 12'h000;
        end else begin
            lo_q_ff <= lo;
            if (side1_power_ok_in || !side2_power_ok_in || lo != lo_q_ff) begin
                dn_ff <= 12'h000;
            end else if (clk_en_in && dn_ff != 12'hFFF) begin
                dn_ff <= dn_ff + 12'h001;
            end
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    a_reset_level: assert property ($rose(rst_b_in) |-> outs == WD_LEVEL)
        else $error("outputs not at default after reset");
    a_clk_freeze: assert property (!clk_en_in |=> $stable(outs))
        else $error("outputs moved with clock enable low");
    a_wd_fires: assert property (
        lo && dn_ff == 12'h834 |-> ((outs ^ WD_LEVEL) & CHAN_DIR) == 4'h0)
        else $error("watchdog default not reached");
    // Last refresh may be 1400 cycles old, so the first 512 are safe
    a_wd_early: assert property (
        lo && dn_ff >= 12'h010 && dn_ff < 12'h200 |-> $stable(outs & CHAN_DIR))
        else $error("watchdog fired too early");
    a_lowpow_hold: assert property (!lo && dn_ff >= 12'h010 |-> $stable(outs & CHAN_DIR))
        else $error("output moved in low power mode");
    for (genvar i = 0; i < 4; i++) begin : g_ch
        a_edge_follow: assert property (
            stab_ff[i] == 5'h10 |-> outs[i] == ins[i])
            else $error("output does not follow input edge");
        a_out_hold: assert property (stab_ff[i] > 5'h10 |-> $stable(outs[i]))
            else $error("output changed between pulses");
        a_refresh_sync: assert property (rfr_ff[i] == 11'h5DC |-> outs[i] == ins[i])
            else $error("refresh did not restore level");
    end
    c_edge: cover property (stab_ff[0] == 5'h10);
    c_wd: cover property (lo && dn_ff == 12'h834);
    c_refresh: cover property (rfr_ff[0] == 11'h5DC);
endmodule : isorw_chk
bind isorw_top isorw_chk #(.CHAN_DIR(CHAN_DIR), .WD_LEVEL(WD_LEVEL)) u_chk (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
    .side1_refresh_enable_n_in(side1_refresh_enable_n_in),
    .side2_refresh_enable_n_in(side2_refresh_enable_n_in),
    .side1_power_ok_in(side1_power_ok_in), .side2_power_ok_in(side2_power_ok_in),
    .chan_a_in(chan_a_in), .chan_b_in(chan_b_in), .chan_c_in(chan_c_in), .chan_d_in(chan_d_in),
    .chan_a_out(chan_a_out), .chan_b_out(chan_b_out), .chan_c_out(chan_c_out),
    .chan_d_out(chan_d_out)
);
`default_nettype wire

// ==== dv/isorw_host_model.sv ====
// Purpose: Host logic on the far side, driving channel pins and enables
// Assumes: Bench sets requests at the rising edge
// Notes:   One request bit feeds both enables so they never disagree
`timescale 1ns/1ns
`default_nettype none
module isorw_host_model (
    // Requests from the bench
    input  wire logic [3:0] lvl_req_in,
    input  wire logic       refresh_off_req_in,
    // Pins toward the isolator
    output logic [3:0]      pins_out,
    output logic            en1_n_out,
    output logic            en2_n_out
);
    // Levels pass straight on; width is the bench's business
    assign pins_out  = lvl_req_in;
    // Shared source keeps both sides in one mode
    assign en1_n_out = refresh_off_req_in;
    assign en2_n_out = refresh_off_req_in;
endmodule : isorw_host_model
`default_nettype wire

// ==== dv/isorw_tb_top.sv ====
// Purpose: Self-checking bench for the four-channel isolator
// Assumes: Default direction, side 1 feeds a and b
// Notes:   Watchdog pattern differs per channel to tell it from a hold
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import isorw_pkg::*;
    ;
    localparam logic [3:0] WDL = 4'h6;
    logic             sys_clk = 1'h0;
    logic             rst_b   = 1'h0;
    logic             clk_en  = 1'h1;
    logic             p1      = 1'h1;
    logic             p2      = 1'h1;
    logic             off     = 1'h0;
    logic [3:0]       lvl     = 4'h0;
    wire  logic [3:0] pins, outs;
    wire  logic       en1_n, en2_n;
    int               num_errors = 0;
    int               checks_done = 0;
    int               cycles = 0;
    isorw_host_model host (.lvl_req_in(lvl), .refresh_off_req_in(off), .pins_out(pins),
        .en1_n_out(en1_n), .en2_n_out(en2_n));
    isorw_top #(.WD_LEVEL(WDL)) dut (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .clk_en_in(clk_en),
        .side1_refresh_enable_n_in(en1_n), .side2_refresh_enable_n_in(en2_n),
        .side1_power_ok_in(p1), .side2_power_ok_in(p2),
        .chan_a_in(pins[0]), .chan_b_in(pins[1]), .chan_c_in(pins[2]), .chan_d_in(pins[3]),
        .chan_a_out(outs[0]), .chan_b_out(outs[1]), .chan_c_out(outs[2]), .chan_d_out(outs[3]));
    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;
    // Cut a hang short; the run needs about 10k cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("MISMATCH timeout expected end seen hang");
            conclude();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] s);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic t_edges();
        lvl <= 4'hF;
        cyc(20);
        lvl <= 4'h0;
        cyc(20);
        chk("fall", 4'h0, outs);
        clk_en <= 1'h0;
        lvl <= 4'h5;
        cyc(20);
        chk("frozen", 4'h0, outs);
        clk_en <= 1'h1;
        cyc(20);
        chk("thawed", 4'h5, outs);
        lvl <= 4'hA;
        cyc(20);
        chk("swap", 4'hA, outs);
        $display("test edges done");
    endtask : t_edges
    task automatic t_glitch();
        logic [3:0] seen;
        // Every width under the threshold, then one above it
        for (int w = 1; w < GLITCH_CYC; w++) begin
            lvl <= 4'hF;
            cyc(w);
            lvl <= 4'hA;
            seen = 4'h0;
            // Watch every cycle: a leaked pulse ends at the same level
            repeat (20) begin
                cyc(1);
                seen = seen | (outs ^ 4'hA);
            end
            chk("glitch", 4'h0, seen);
        end
        lvl <= 4'hF;
        cyc(12);
        chk("wide pulse", 4'hF, outs);
        lvl <= 4'hA;
        cyc(20);
        $display("test glitch done");
    endtask : t_glitch
    task automatic t_lowpow();
        off <= 1'h1;
        lvl <= 4'h3;
        cyc(20);
        p2 <= 1'h0;
        cyc(20);
        chk("side2 down", (WDL & DIR_DEFAULT) | (4'h3 & ~DIR_DEFAULT), outs);
        lvl <= 4'h0;
        cyc(20);
        p2 <= 1'h1;
        cyc(1500);
        chk("no transfer", WDL & DIR_DEFAULT, outs);
        lvl <= 4'h3;
        cyc(20);
        lvl <= 4'h0;
        cyc(20);
        chk("dummy edge", 4'h0, outs);
        p1 <= 1'h0;
        cyc(2200);
        chk("no watchdog", WDL & ~DIR_DEFAULT, outs);
        p1 <= 1'h1;
        cyc(20);
        $display("test low power done");
    endtask : t_lowpow
    task automatic t_refresh();
        off <= 1'h0;
        lvl <= 4'h3;
        cyc(20);
        p2 <= 1'h0;
        cyc(20);
        lvl <= 4'h0;
        cyc(20);
        p2 <= 1'h1;
        cyc(1520);
        chk("refresh", 4'h0, outs);
        p1 <= 1'h0;
        cyc(500);
        chk("wd early", WDL & ~DIR_DEFAULT, outs);
        cyc(1700);
        chk("wd fired", WDL, outs);
        p1 <= 1'h1;
        cyc(1520);
        chk("wd recovered", 4'h0, outs);
        $display("test refresh done");
    endtask : t_refresh
    // Reset for three cycles, then the scenarios in turn
    initial begin
        cyc(3);
        rst_b <= 1'h1;
        cyc(2);
        t_edges();
        t_glitch();
        t_lowpow();
        t_refresh();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
